// ---- shared/seer_defines.svh ----
// Constants of the serial EEPROM instruction engine: field codes,
// expected clock-pulse counts and timing figures.
// Assumes a 40 MHz system clock; included by the package and the top.
`ifndef SEER_DEFINES_SVH
`define SEER_DEFINES_SVH

`define SEER_ADDR_W 8
`define SEER_WORD_W 16
`define SEER_DEPTH 256
`define SEER_PAGE_WORDS 4
`define SEER_HDR_BITS 10
`define SEER_HDR_LAST 4'h9
`define SEER_BIT_LAST 4'hf

`define SEER_OP_READ 2'h2
`define SEER_OP_WORD 2'h1
`define SEER_OP_PAGE 2'h3
`define SEER_OP_SPECIAL 2'h0
`define SEER_SUB_FILL 2'h1
`define SEER_SUB_ENABLE 2'h3
`define SEER_SUB_DISABLE 2'h0

`define SEER_CNT_WORD 8'h1b
`define SEER_CNT_PAGE_BASE 8'h0b
`define SEER_CNT_PER_WORD 8'h10
`define SEER_CNT_MAX 8'hff

`define SEER_CLK_PERIOD_NS 25
`define SEER_PROG_TIME_NS 1000000
`define SEER_SLSH_NS 250
`define SEER_CYCLES_MIN(t) (((t) + `SEER_CLK_PERIOD_NS - 1) / `SEER_CLK_PERIOD_NS)

`endif

// ---- shared/seer_pkg.sv ----
// Types shared by the serial EEPROM instruction engine.
// Assumes the defines header sits beside it on the include path.
`include "seer_defines.svh"

package seer_pkg;

  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE, ST_HDR, ST_READ, ST_DATA, ST_SKIP, ST_PROG
  } seer_state_t;

  // Kind of pending programming job
  typedef enum logic [1:0] {
    JOB_NONE, JOB_WORD, JOB_PAGE, JOB_FILL
  } seer_job_t;

  // Serial pins after the synchroniser
  typedef struct packed {
    logic cs;
    logic sclk;
    logic din;
    logic wpen;
  } seer_pins_t;

endpackage

// ---- design/seer_pin_sync.sv ----
// Three-flop synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous pin inputs; output changes once stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none

module seer_pin_sync #(
  parameter int W = 4
) (
  input wire logic clock, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic ce, // Clock enable
  input wire logic [W-1:0] pinIn, // Raw pins
  output logic [W-1:0] level // Filtered levels
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : gLane
      logic s1_q, s2_q, s3_q, lvl_q;
      logic lvl_d;
      // Stage 1 feeds only stage 2, never the filter
      always_comb begin
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
      end
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
        end else if (ce) begin
          s1_q <= pinIn[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          lvl_q <= lvl_d;
        end
      end
      assign level[g] = lvl_q;
    end
  endgenerate

endmodule

`default_nettype wire

// ---- design/seer_prog_timer.sv ----
// Self-timed programming interval on the system clock.
// Assumes a one-cycle start pulse; done is a one-cycle pulse at the end.
`timescale 1ns/1ps
`default_nettype none

module seer_prog_timer #(
  parameter int CYCLES = 40000
) (
  input wire logic clock, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic ce, // Clock enable
  input wire logic start, // Begin a programming interval
  output logic done // Pulse when the interval ends
);

  logic [23:0] cnt_q, cnt_d;
  logic done_q, done_d;

  // Down counter, independent of the serial clock
  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = 24'(CYCLES);
    end else if (cnt_q != 24'h0) begin
      cnt_d = cnt_q - 24'h1;
      done_d = (cnt_q == 24'h1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= 24'h0;
      done_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

endmodule

`default_nettype wire

// ---- design/seer_engine.sv ----
// Instruction engine of a 16-bit serial EEPROM: read, write latch,
// word write, page write, fill-all and self-timed programming.
// Assumes pins arrive asynchronously; protection state from local logic.
`timescale 1ns/1ps
`default_nettype none
`include "seer_defines.svh"

// Behaviour
// - Start bit after select rises, clock low
// - Eight address bits follow start and op-code
// - Read emits dummy zero then word MSB-first
// - Output changes on serial clock rising edges
// - Held select streams next words, no dummy
// - Write latch disabled after reset
// - Latch stays enabled until disable or reset
// - Read ignores the write latch
// - Word write: start, op, address, 16 bits
// - Input bits sampled on clock rising edges
// - Select must fall right after last bit
// - Polled output low busy, high ready
// - Inputs ignored while programming
// - Ready stays high until start or deselect
// - Programming timed by internal clock
// - Page write carries one to four words
// - Page address wraps in two low bits
// - Page refused if any page word protected
// - Fill-all needs cleared protection register
// - Fill-all writes every location at once
// - Pulse count mismatch aborts write instructions
module seer_engine
  import seer_pkg::*;
#(
  parameter int PROG_CYCLES = `SEER_CYCLES_MIN(`SEER_PROG_TIME_NS)
) (
  input wire logic clock, // 40 MHz system clock
  input wire logic rst, // Async reset, active high
  input wire logic ce, // Clock enable
  input wire logic chipSel, // Chip select pin
  input wire logic serClk, // Serial clock pin
  input wire logic serDin, // Serial data in pin
  input wire logic writeEnPin, // Write-enable pin
  input wire logic [7:0] protBound, // Lowest protected address
  input wire logic protCleared, // Protection register cleared
  output logic serDout, // Serial data out
  output logic serDoutOe, // Serial data out enable
  output logic progBusy // Programming in progress
);

  localparam int SLSH_CYCLES = `SEER_CYCLES_MIN(`SEER_SLSH_NS);

  seer_pins_t pinRaw, pin;
  logic [3:0] pinLvl;
  logic sclkPrev_q, csPrev_q;
  logic sclkRise, csRise;
  logic progStart, progDone;

  seer_state_t state_q, state_d;
  seer_job_t job_q, job_d;
  logic [3:0] hdrCnt_q, hdrCnt_d;
  logic [9:0] hdr_q, hdr_d;
  logic [7:0] addr_q, addr_d;
  logic [15:0] shift_q, shift_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [2:0] wordCnt_q, wordCnt_d;
  logic [7:0] pulseCnt_q, pulseCnt_d;
  logic [15:0] page_q [`SEER_PAGE_WORDS];
  logic [15:0] page_d [`SEER_PAGE_WORDS];
  logic [3:0] slshCnt_q, slshCnt_d;
  logic wel_q, wel_d;
  logic armed_q, armed_d;
  logic readyShow_q, readyShow_d;
  logic sdo_q, sdo_d, sdoOe_q, sdoOe_d, busy_q, busy_d;

  logic [15:0] mem [`SEER_DEPTH];
  logic [9:0] hdrNext;
  logic [15:0] wordNext;
  logic [7:0] pageTop;
  logic [7:0] pulseInc;
  logic slshOk, gateOk, jobOk;

  assign pinRaw = '{cs: chipSel, sclk: serClk, din: serDin, wpen: writeEnPin};

  seer_pin_sync #(
    .W(4)
  ) uSync (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .pinIn(pinRaw),
    .level(pinLvl)
  );

  seer_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) uTimer (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .start(progStart),
    .done(progDone)
  );

  // Edges of the filtered serial clock and select
  assign pin = pinLvl;
  assign sclkRise = pin.sclk & ~sclkPrev_q;
  assign csRise = pin.cs & ~csPrev_q;

  // Helpers for decode and the abort check
  assign hdrNext = {hdr_q[8:0], pin.din};
  assign wordNext = {shift_q[14:0], pin.din};
  assign pageTop = {addr_q[7:2], 2'h3};
  assign pulseInc = (pulseCnt_q == `SEER_CNT_MAX) ? pulseCnt_q
                    : pulseCnt_q + 8'h1;
  assign slshOk = (slshCnt_q == 4'(SLSH_CYCLES));
  assign gateOk = wel_q & pin.wpen;

  // Legality of the pending job at deselect
  always_comb begin
    jobOk = 1'b0;
    unique case (job_q)
      JOB_WORD: jobOk = (pulseCnt_q == `SEER_CNT_WORD)
                        && (wordCnt_q == 3'h1)
                        && (protCleared || addr_q < protBound);
      JOB_PAGE: jobOk = (wordCnt_q != 3'h0)
                        && (wordCnt_q <= 3'(`SEER_PAGE_WORDS))
                        && (pulseCnt_q == 8'(`SEER_CNT_PAGE_BASE
                            + `SEER_CNT_PER_WORD * wordCnt_q))
                        && (protCleared || pageTop < protBound);
      JOB_FILL: jobOk = (pulseCnt_q == `SEER_CNT_WORD)
                        && (wordCnt_q == 3'h1)
                        && protCleared;
      JOB_NONE: jobOk = 1'b0;
    endcase
  end

  // Instruction sequencer
  always_comb begin
    state_d = state_q;
    job_d = job_q;
    hdrCnt_d = hdrCnt_q;
    hdr_d = hdr_q;
    addr_d = addr_q;
    shift_d = shift_q;
    bitCnt_d = bitCnt_q;
    wordCnt_d = wordCnt_q;
    pulseCnt_d = pulseCnt_q;
    page_d = page_q;
    slshCnt_d = slshCnt_q;
    wel_d = wel_q;
    armed_d = armed_q;
    readyShow_d = readyShow_q;
    sdo_d = sdo_q;
    sdoOe_d = sdoOe_q;
    busy_d = busy_q;
    progStart = 1'b0;
    if (csRise && !pin.sclk) begin
      armed_d = 1'b1;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (!pin.cs) begin
          armed_d = 1'b0;
          readyShow_d = 1'b0;
          sdoOe_d = 1'b0;
        end else if (armed_q && sclkRise && pin.din) begin
          // Start bit; pulse count includes it
          state_d = ST_HDR;
          hdrCnt_d = 4'h0;
          pulseCnt_d = 8'h1;
          armed_d = 1'b0;
          readyShow_d = 1'b0;
          sdoOe_d = 1'b0;
        end else if (readyShow_q) begin
          sdo_d = 1'b1;
          sdoOe_d = 1'b1;
        end
      end
      ST_HDR: begin
        if (!pin.cs) begin
          state_d = ST_IDLE;
        end else if (sclkRise) begin
          hdr_d = hdrNext;
          hdrCnt_d = hdrCnt_q + 4'h1;
          pulseCnt_d = pulseInc;
          if (hdrCnt_q == `SEER_HDR_LAST) begin
            addr_d = hdrNext[7:0];
            bitCnt_d = 4'h0;
            wordCnt_d = 3'h0;
            job_d = JOB_NONE;
            state_d = ST_DATA;
            unique case (hdrNext[9:8])
              `SEER_OP_READ: begin
                // Latch state not consulted here
                shift_d = mem[hdrNext[7:0]];
                sdo_d = 1'b0;
                sdoOe_d = 1'b1;
                state_d = ST_READ;
              end
              `SEER_OP_WORD: job_d = JOB_WORD;
              `SEER_OP_PAGE: job_d = JOB_PAGE;
              `SEER_OP_SPECIAL: begin
                state_d = ST_SKIP;
                unique case (hdrNext[7:6])
                  `SEER_SUB_FILL: begin
                    job_d = JOB_FILL;
                    state_d = ST_DATA;
                  end
                  `SEER_SUB_ENABLE: begin
                    if (pin.wpen) begin
                      wel_d = 1'b1;
                    end
                  end
                  `SEER_SUB_DISABLE: wel_d = 1'b0;
                  default: wel_d = wel_q;
                endcase
              end
            endcase
          end
        end
      end
      ST_READ: begin
        if (!pin.cs) begin
          sdoOe_d = 1'b0;
          state_d = ST_IDLE;
        end else if (sclkRise) begin
          sdo_d = shift_q[15];
          shift_d = {shift_q[14:0], 1'b0};
          bitCnt_d = bitCnt_q + 4'h1;
          if (bitCnt_q == `SEER_BIT_LAST) begin
            // Next word follows at once, no dummy
            addr_d = addr_q + 8'h1;
            shift_d = mem[addr_q + 8'h1];
          end
        end
      end
      ST_DATA: begin
        if (!pin.cs) begin
          if (jobOk && gateOk) begin
            progStart = 1'b1;
            busy_d = 1'b1;
            slshCnt_d = 4'h0;
            sdoOe_d = 1'b0;
            state_d = ST_PROG;
          end else begin
            state_d = ST_IDLE;
          end
        end else if (sclkRise) begin
          shift_d = wordNext;
          bitCnt_d = bitCnt_q + 4'h1;
          pulseCnt_d = pulseInc;
          if (bitCnt_q == `SEER_BIT_LAST) begin
            if (wordCnt_q < 3'(`SEER_PAGE_WORDS)) begin
              page_d[wordCnt_q[1:0]] = wordNext;
            end
            // Saturates so a ninth word still fails the count
            if (wordCnt_q != 3'h7) begin
              wordCnt_d = wordCnt_q + 3'h1;
            end
          end
        end
      end
      ST_SKIP: begin
        if (!pin.cs) begin
          state_d = ST_IDLE;
        end
      end
      ST_PROG: begin
        // Serial input disregarded until done
        if (!pin.cs && !slshOk) begin
          slshCnt_d = slshCnt_q + 4'h1;
        end
        sdo_d = 1'b0;
        sdoOe_d = pin.cs && slshOk;
        if (progDone) begin
          busy_d = 1'b0;
          job_d = JOB_NONE;
          readyShow_d = 1'b1;
          sdo_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers; latch clears on reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      job_q <= JOB_NONE;
      hdrCnt_q <= 4'h0;
      hdr_q <= 10'h0;
      addr_q <= 8'h0;
      shift_q <= 16'h0;
      bitCnt_q <= 4'h0;
      wordCnt_q <= 3'h0;
      pulseCnt_q <= 8'h0;
      for (int i = 0; i < `SEER_PAGE_WORDS; i++) begin
        page_q[i] <= 16'h0;
      end
      slshCnt_q <= 4'h0;
      wel_q <= 1'b0;
      armed_q <= 1'b0;
      readyShow_q <= 1'b0;
      sdo_q <= 1'b0;
      sdoOe_q <= 1'b0;
      busy_q <= 1'b0;
      sclkPrev_q <= 1'b0;
      csPrev_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      job_q <= job_d;
      hdrCnt_q <= hdrCnt_d;
      hdr_q <= hdr_d;
      addr_q <= addr_d;
      shift_q <= shift_d;
      bitCnt_q <= bitCnt_d;
      wordCnt_q <= wordCnt_d;
      pulseCnt_q <= pulseCnt_d;
      page_q <= page_d;
      slshCnt_q <= slshCnt_d;
      wel_q <= wel_d;
      armed_q <= armed_d;
      readyShow_q <= readyShow_d;
      sdo_q <= sdo_d;
      sdoOe_q <= sdoOe_d;
      busy_q <= busy_d;
      sclkPrev_q <= pin.sclk;
      csPrev_q <= pin.cs;
    end
  end

  // Array commits at the end of the interval, never mid-cycle
  always_ff @(posedge clock) begin
    if (ce && progDone && state_q == ST_PROG) begin
      unique case (job_q)
        JOB_WORD: mem[addr_q] <= page_q[0];
        JOB_PAGE: begin
          for (int k = 0; k < `SEER_PAGE_WORDS; k++) begin
            if (3'(k) < wordCnt_q) begin
              mem[{addr_q[7:2], addr_q[1:0] + 2'(k)}] <= page_q[k];
            end
          end
        end
        JOB_FILL: begin
          for (int k = 0; k < `SEER_DEPTH; k++) begin
            mem[k] <= page_q[0];
          end
        end
        JOB_NONE: ;
      endcase
    end
  end

  assign serDout = sdo_q;
  assign serDoutOe = sdoOe_q;
  assign progBusy = busy_q;

endmodule

`default_nettype wire

// ---- bench/seer_monitor.sv ----
// Concurrent checks on the pins of the serial EEPROM engine.
// Assumes PROG_CYCLES is handed on from the bound engine instance.
`timescale 1ns/1ps
`default_nettype none

module seer_monitor #(
  parameter int PROG_CYCLES = 40000
) (
  input wire logic clock, // System clock
  input wire logic rst, // Async reset
  input wire logic ce, // Clock enable
  input wire logic chipSel, // Select pin
  input wire logic serClk, // Serial clock pin
  input wire logic serDin, // Serial data in
  input wire logic writeEnPin, // Write-enable pin
  input wire logic [7:0] protBound, // Lowest protected word
  input wire logic protCleared, // Protection cleared
  input wire logic serDout, // Serial data out
  input wire logic serDoutOe, // Output enable
  input wire logic progBusy // Programming flag
);
  logic [31:0] busyCnt_q;
  logic [31:0] busyCnt_d;

  // Length of the running programming interval
  always_comb begin
    busyCnt_d = progBusy ? busyCnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busyCnt_q <= 32'h0;
    end else begin
      busyCnt_q <= busyCnt_d;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence progStart;
    $rose(progBusy);
  endsequence
  // Eight idle clocks cover the synchroniser plus output register
  sequence deselected;
    !chipSel [*8];
  endsequence

  sel_low_a: assert property (progStart |-> !chipSel)
    else $error("programming began while selected");
  busy_min_a: assert property (progStart |-> progBusy [*8])
    else $error("programming cut short");
  busy_max_a: assert property (
    progBusy |-> busyCnt_q < PROG_CYCLES + 4)
    else $error("programming overran its interval");
  busy_low_a: assert property (
    progBusy && $past(progBusy) && serDoutOe |-> !serDout)
    else $error("busy status not low");
  ready_high_a: assert property ($fell(progBusy) |-> serDout)
    else $error("ready status not high");
  oe_off_a: assert property (deselected |-> !serDoutOe)
    else $error("output driven while deselected");
  out_clk_a: assert property (
    serDoutOe && $past(serDoutOe) && !progBusy && !$past(progBusy)
    && $changed(serDout) |-> $past(serClk, 3) || $past(serClk, 4)
    || $past(serClk, 5) || $past(serClk, 6))
    else $error("output changed without a clock rise");
  w_pin_a: assert property (progStart |-> $past(writeEnPin, 6))
    else $error("programming with write pin low");
endmodule

bind seer_engine seer_monitor #(.PROG_CYCLES(PROG_CYCLES)) seer_monitor_inst (
  .clock(clock), .rst(rst), .ce(ce), .chipSel(chipSel), .serClk(serClk),
  .serDin(serDin), .writeEnPin(writeEnPin), .protBound(protBound),
  .protCleared(protCleared), .serDout(serDout), .serDoutOe(serDoutOe),
  .progBusy(progBusy));

`default_nettype wire

// ---- bench/seer_host.sv ----
// Host side of the three-wire link: select, clock and data in.
// Assumes callers start each task 1 ns after a 25 ns clock edge.
`timescale 1ns/1ps
`default_nettype none

module seer_host (
  output logic chipSel, // Select pin
  output logic serClk, // Serial clock, still between frames
  output logic serDin, // Serial data in
  input wire logic serDout // Serial data out
);
  initial begin
    chipSel = 1'b0;
    serClk = 1'b0;
    serDin = 1'b0;
  end

  // One 200 ns clock period; data stays put 100 ns each side of the rise
  task automatic pulse(input logic d, output logic q);
    serDin = d;
    #100;
    q = serDout; // Bit launched by the previous rise
    serClk = 1'b1;
    #100;
    serClk = 1'b0;
  endtask

  // Select rises while the clock is low
  task automatic sel();
    chipSel = 1'b1;
    #100;
  endtask

  // Drop select right after the last fall; released data is inverted
  task automatic desel();
    chipSel = 1'b0;
    serDin = ~serDin;
    #400;
  endtask

  // Start bit, op-code and eight address bits
  task automatic hdr(input logic [10:0] h);
    logic q;
    for (int i = 10; i >= 0; i--) begin
      pulse(h[i], q);
    end
  endtask

  task automatic wrw(input logic [15:0] w);
    logic q;
    for (int i = 15; i >= 0; i--) begin
      pulse(w[i], q);
    end
  endtask

  task automatic rdw(output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      pulse(1'b0, r[i]);
    end
  endtask
endmodule

`default_nettype wire

// ---- bench/test_seer_engine.sv ----
// Self-checking bench of the serial EEPROM instruction engine.
// Assumes the host model drives the pins; programming shortened to 50.
`timescale 1ns/1ps
`default_nettype none
`include "seer_defines.svh"

module test_seer_engine;
  import seer_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [15:0] d;
    logic w;
    logic [15:0] q;
  } seer_row_t;
  logic clock, rst, ce, chipSel, serClk, serDin, writeEnPin, protCleared;
  logic serDout, serDoutOe, progBusy, q;
  logic sdoLine;
  logic [7:0] protBound;
  logic [15:0] r;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  // Address, data, write pin, expected read-back
  seer_row_t rows [4] = '{'{8'h00, 16'h1234, 1'b1, 16'h1234},
    '{8'hff, 16'h8001, 1'b1, 16'h8001}, '{8'h00, 16'hbeef, 1'b0, 16'h1234},
    '{8'h5a, 16'ha5a5, 1'b1, 16'ha5a5}};

  seer_engine #(.PROG_CYCLES(50)) seer_engine_inst (.clock(clock),
    .rst(rst), .ce(ce), .chipSel(chipSel), .serClk(serClk),
    .serDin(serDin), .writeEnPin(writeEnPin), .protBound(protBound),
    .protCleared(protCleared), .serDout(serDout), .serDoutOe(serDoutOe),
    .progBusy(progBusy));
  // Undriven data line shows the inverse, so a missing enable shows up
  assign sdoLine = serDoutOe ? serDout : ~serDout;
  seer_host seer_host_inst (.chipSel(chipSel), .serClk(serClk),
    .serDin(serDin), .serDout(sdoLine));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [10:0] h);
    seer_host_inst.sel();
    seer_host_inst.hdr(h);
    seer_host_inst.desel();
  endtask

  // Full instruction with one data word
  task automatic wr(input logic [10:0] h, input logic [15:0] d);
    seer_host_inst.sel();
    seer_host_inst.hdr(h);
    seer_host_inst.wrw(d);
    seer_host_inst.desel();
  endtask

  // Busy expected or not, then bounded wait for the end
  task automatic wt(input logic b);
    chk({15'h0, progBusy}, {15'h0, b});
    for (int i = 0; i < 200 && progBusy !== 1'b0; i++) begin
      @(posedge clock);
    end
    #1;
    // A cycle that never ends counts as a mismatch
    chk({15'h0, progBusy}, 16'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    seer_host_inst.sel();
    seer_host_inst.hdr({1'b1, `SEER_OP_READ, a});
    seer_host_inst.pulse(1'b0, q);
    chk({15'h0, q}, 16'h0);
    seer_host_inst.rdw(r);
    chk(r, e);
    seer_host_inst.desel();
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    writeEnPin = 1'b1;
    protBound = 8'hf0;
    protCleared = 1'b1;
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    chk({13'h0, serDout, serDoutOe, progBusy}, 16'h0);
    wr({1'b1, `SEER_OP_WORD, 8'h10}, 16'h1111);
    wt(1'b0);
    cmd({1'b1, `SEER_OP_SPECIAL, `SEER_SUB_ENABLE, 6'h00});
    foreach (rows[i]) begin
      writeEnPin = rows[i].w;
      wr({1'b1, `SEER_OP_WORD, rows[i].a}, rows[i].d);
      wt(rows[i].w);
      writeEnPin = 1'b1;
      rd(rows[i].a, rows[i].q);
    end
    // Stream across the top address into word zero
    seer_host_inst.sel();
    seer_host_inst.hdr({1'b1, `SEER_OP_READ, 8'hff});
    seer_host_inst.pulse(1'b0, q);
    seer_host_inst.rdw(r);
    chk(r, 16'h8001);
    seer_host_inst.rdw(r);
    chk(r, 16'h1234);
    seer_host_inst.desel();
    // Poll busy, then ready held while selected
    wr({1'b1, `SEER_OP_WORD, 8'h20}, 16'h2222);
    seer_host_inst.sel();
    seer_host_inst.pulse(1'b1, q);
    chk({14'h0, serDoutOe, serDout}, 16'h2);
    wt(1'b1);
    #200;
    chk({14'h0, serDoutOe, serDout}, 16'h3);
    #400;
    chk({14'h0, serDoutOe, serDout}, 16'h3);
    seer_host_inst.desel();
    rd(8'h20, 16'h2222);
    // One clock too many before deselect
    seer_host_inst.sel();
    seer_host_inst.hdr({1'b1, `SEER_OP_WORD, 8'h20});
    seer_host_inst.wrw(16'h3333);
    seer_host_inst.pulse(1'b0, q);
    seer_host_inst.desel();
    wt(1'b0);
    rd(8'h20, 16'h2222);
    // Three-word page wraps inside its four-word page
    seer_host_inst.sel();
    seer_host_inst.hdr({1'b1, `SEER_OP_PAGE, 8'h5e});
    seer_host_inst.wrw(16'haaaa);
    seer_host_inst.wrw(16'hbbbb);
    seer_host_inst.wrw(16'hcccc);
    seer_host_inst.desel();
    wt(1'b1);
    rd(8'h5e, 16'haaaa);
    rd(8'h5f, 16'hbbbb);
    rd(8'h5c, 16'hcccc);
    // Page whose last word touches the protected bound
    protCleared = 1'b0;
    protBound = 8'h5f;
    wr({1'b1, `SEER_OP_PAGE, 8'h5c}, 16'hdddd);
    wt(1'b0);
    rd(8'h5c, 16'hcccc);
    wr({1'b1, `SEER_OP_SPECIAL, `SEER_SUB_FILL, 6'h00}, 16'h0f0f);
    wt(1'b0);
    protCleared = 1'b1;
    wr({1'b1, `SEER_OP_SPECIAL, `SEER_SUB_FILL, 6'h00}, 16'h0f0f);
    wt(1'b1);
    rd(8'h00, 16'h0f0f);
    rd(8'hff, 16'h0f0f);
    // Disable after writing; reads still work
    cmd({1'b1, `SEER_OP_SPECIAL, `SEER_SUB_DISABLE, 6'h00});
    wr({1'b1, `SEER_OP_WORD, 8'h00}, 16'h5555);
    wt(1'b0);
    rd(8'h00, 16'h0f0f);
    // Reset in mid-run drops an enabled latch
    cmd({1'b1, `SEER_OP_SPECIAL, `SEER_SUB_ENABLE, 6'h00});
    rst = 1'b1;
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    chk({13'h0, serDout, serDoutOe, progBusy}, 16'h0);
    wr({1'b1, `SEER_OP_WORD, 8'h00}, 16'h5555);
    wt(1'b0);
    rd(8'h00, 16'h0f0f);
    finish_test();
  end
endmodule

`default_nettype wire
